// file: design/thresh_mon_regs.vh
// Register offsets, field positions, reset values and state codes for the
// discrete threshold-monitor handshake port.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef THRESH_MON_REGS_VH
`define THRESH_MON_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define TM_CTRL_OFS 8'h00
`define TM_STATE_OFS 8'h04
`define TM_IRQ_STAT_OFS 8'h08
`define TM_IRQ_MASK_OFS 8'h0C
`define TM_COND_IDX_OFS 8'h10
`define TM_COND_DATA_OFS 8'h14
`define TM_ZERO_CNT_OFS 8'h18

// ------------------------------------------------------------------
// Control fields (command bits self-clear)
// ------------------------------------------------------------------
`define TM_CTRL_SAVE 0
`define TM_CTRL_RELOAD 1
`define TM_CTRL_ZERO 2
`define TM_CTRL_PAUSE 3
`define TM_CTRL_SWERR 4
`define TM_CTRL_RESET 32'h00000000

// ------------------------------------------------------------------
// Condition entry fields: select code, result code, enable
// ------------------------------------------------------------------
`define TM_COND_SEL_LSB 0
`define TM_COND_RES_LSB 4
`define TM_COND_EN 8

// ------------------------------------------------------------------
// Interrupt bits
// ------------------------------------------------------------------
`define TM_IRQ_HIT 0
`define TM_IRQ_ZERO 1
`define TM_IRQ_FAULT 2
`define TM_IRQ_RESET 3'h0

// ------------------------------------------------------------------
// Handshake states
// ------------------------------------------------------------------
`define TM_ST_IDLE 2'h0
`define TM_ST_SCAN 2'h1
`define TM_ST_PRESENT 2'h2
`define TM_ST_HOLD 2'h3

`endif

// file: design/thresh_mon_port.v
// Discrete handshake port of a force/torque controller with register
// access over Avalon-MM. Discrete pins are slow asynchronous levels;
// condition truth comes from the threshold engine on core_clk.
//
// What this block does
// - The four select lines form one 4-bit code choosing conditions to scan.
// - Select lines are latched only on a rising edge of scan request.
// - Each zeroing strobe rising edge runs exactly one zeroing operation.
// - Fault-free line is high normally and low while any error exists.
// - Only conditions whose select code equals the latched code are evaluated.
// - While scan request is high, scan repeatedly and present true results.
// - Several triggered conditions present the bitwise OR of their codes.
// - Result-valid rises only after the result code is on the lines.
// - Scanning halts while result-valid is high, freezing the result.
// - Scan request low clears the result and drops result-valid.
// - Conditions live in working storage, reloaded from saved copy on reset.
// - Fault-free drops together with the error indicator, e.g. on saturation.
// - A flow-control pause stalls the handshake; timing is then unbounded.
`timescale 1ns/1ps
`include "thresh_mon_regs.vh"

module thresh_mon_port #(
  parameter NUM_COND = 16,
  parameter IDX_W = 4
) (
  // Clock and synchronous reset.
  input wire core_clk,
  input wire rst,
  // Avalon-MM slave.
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Discrete pins from the external controller.
  input wire [3:0] selectIn,
  input wire scanReq,
  input wire zeroStrobe,
  // Discrete pins to the external controller.
  output reg [3:0] resultOut,
  output reg resultValid,
  output reg faultFree,
  // Threshold engine side.
  input wire [NUM_COND-1:0] condTrue,
  input wire sensorSaturated,
  output reg zeroOffsetCmd,
  output reg saveWorkingStoreCmd,
  output reg errorLed,
  output reg irq
);

  // ------------------------------------------------------------------
  // Storage and state
  // ------------------------------------------------------------------
  reg [8:0] workStore_q [0:NUM_COND-1];
  reg [8:0] savedStore_q [0:NUM_COND-1];
  reg [3:0] selSync1_q, selSync2_q;
  reg [1:0] scanSync_q, zeroSync_q;
  reg scanPrev_q, zeroPrev_q;
  reg [3:0] selLatched_q;
  reg [1:0] state_q;
  reg pause_q, swErr_q;
  reg [2:0] irqStat_q, irqMask_q;
  reg [IDX_W-1:0] condIdx_q;
  reg [15:0] zeroCnt_q;
  reg saveReq_q, reloadReq_q, zeroReq_q, faultPrev_q;
  reg [3:0] hitAcc;
  wire scanLvl = scanSync_q[1];
  wire scanRise = scanSync_q[1] & ~scanPrev_q;
  wire zeroRise = zeroSync_q[1] & ~zeroPrev_q;
  wire wrAck = write & ~waitrequest;
  wire errNow = sensorSaturated | swErr_q;
  wire hitEvt = (state_q == `TM_ST_PRESENT);
  wire zeroEvt = zeroRise | zeroReq_q;
  wire faultEvt = errNow & ~faultPrev_q;
  wire [2:0] irqEvt = {faultEvt, zeroEvt, hitEvt};
  // Each loop has its own index, so no variable is written by both the
  // combinational scan and the clocked storage process.
  integer i;
  integer j;

  // Address match helper shared by read and write decode.
  function isReg;
    input [7:0] a;
    input [7:0] ofs;
    begin
      isReg = (a == ofs);
    end
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // The first stage feeds only the second; edges are taken on stage two.
  always @(posedge core_clk)
  begin
    selSync1_q <= selectIn;
    selSync2_q <= selSync1_q;
    scanSync_q <= {scanSync_q[0], scanReq};
    zeroSync_q <= {zeroSync_q[0], zeroStrobe};
    if (rst)
    begin
      scanPrev_q <= 1'b0;
      zeroPrev_q <= 1'b0;
    end
    else
    begin
      // Held while paused, so a request that rises during a pause is
      // still seen as an edge once the state machine runs again.
      if (!pause_q)
        scanPrev_q <= scanSync_q[1];
      zeroPrev_q <= zeroSync_q[1];
    end
  end

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  // All entries are compared in parallel, so one cycle is one full scan.
  always @*
  begin
    hitAcc = 4'h0;
    for (i = 0; i < NUM_COND; i = i + 1)
    begin
      if (workStore_q[i][`TM_COND_EN] && condTrue[i] &&
          workStore_q[i][`TM_COND_SEL_LSB +: 4] == selLatched_q)
        hitAcc = hitAcc | workStore_q[i][`TM_COND_RES_LSB +: 4];
    end
  end

  // ------------------------------------------------------------------
  // Handshake state machine
  // ------------------------------------------------------------------
  // Scan request is trusted to follow the controller's ordering; a rise
  // while results are held is ignored until the line falls again.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= `TM_ST_IDLE;
      selLatched_q <= 4'h0;
      resultOut <= 4'h0;
      resultValid <= 1'b0;
    end
    else if (!pause_q)
    begin
      case (state_q)
        `TM_ST_IDLE:
        begin
          if (scanRise)
          begin
            selLatched_q <= selSync2_q;
            state_q <= `TM_ST_SCAN;
          end
        end
        `TM_ST_SCAN:
        begin
          if (!scanLvl)
            state_q <= `TM_ST_IDLE;
          else if (hitAcc != 4'h0)
          begin
            resultOut <= hitAcc;
            state_q <= `TM_ST_PRESENT;
          end
        end
        `TM_ST_PRESENT:
        begin
          resultValid <= 1'b1;
          state_q <= `TM_ST_HOLD;
        end
        `TM_ST_HOLD:
        begin
          // No scanning here, so the presented code cannot move.
          if (!scanLvl)
          begin
            resultOut <= 4'h0;
            resultValid <= 1'b0;
            state_q <= `TM_ST_IDLE;
          end
        end
        default:
          state_q <= `TM_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Zeroing, health and error indicator
  // ------------------------------------------------------------------
  // Both fault outputs come from the same term and switch in one cycle.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      zeroOffsetCmd <= 1'b0;
      zeroCnt_q <= 16'h0000;
      faultFree <= 1'b1;
      errorLed <= 1'b0;
      faultPrev_q <= 1'b0;
    end
    else
    begin
      zeroOffsetCmd <= zeroEvt;
      if (zeroEvt)
        zeroCnt_q <= zeroCnt_q + 16'h0001;
      faultFree <= ~errNow;
      errorLed <= errNow;
      faultPrev_q <= errNow;
    end
  end

  // ------------------------------------------------------------------
  // Working and saved condition storage
  // ------------------------------------------------------------------
  // The saved copy has no reset so it survives reset like permanent memory.
  always @(posedge core_clk)
  begin
    for (j = 0; j < NUM_COND; j = j + 1)
    begin
      if (rst || reloadReq_q)
        workStore_q[j] <= savedStore_q[j];
      else if (wrAck && isReg(address, `TM_COND_DATA_OFS) && condIdx_q == j)
        workStore_q[j] <= writedata[8:0];
      if (!rst && saveReq_q)
        savedStore_q[j] <= workStore_q[j];
    end
  end

  // ------------------------------------------------------------------
  // Register bus slave and interrupts
  // ------------------------------------------------------------------
  // One wait cycle per access; unmapped reads return zero, writes drop.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      pause_q <= 1'b0;
      swErr_q <= 1'b0;
      irqStat_q <= `TM_IRQ_RESET;
      irqMask_q <= `TM_IRQ_RESET;
      condIdx_q <= {IDX_W{1'b0}};
      saveReq_q <= 1'b0;
      reloadReq_q <= 1'b0;
      zeroReq_q <= 1'b0;
      saveWorkingStoreCmd <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // The master must hold its request until it samples this low.
      waitrequest <= ~((read | write) & waitrequest);
      saveReq_q <= wrAck && isReg(address, `TM_CTRL_OFS) && writedata[`TM_CTRL_SAVE];
      reloadReq_q <= wrAck && isReg(address, `TM_CTRL_OFS) && writedata[`TM_CTRL_RELOAD];
      zeroReq_q <= wrAck && isReg(address, `TM_CTRL_OFS) && writedata[`TM_CTRL_ZERO];
      saveWorkingStoreCmd <= saveReq_q;
      if (wrAck && isReg(address, `TM_CTRL_OFS))
      begin
        pause_q <= writedata[`TM_CTRL_PAUSE];
        swErr_q <= writedata[`TM_CTRL_SWERR];
      end
      if (wrAck && isReg(address, `TM_IRQ_MASK_OFS))
        irqMask_q <= writedata[2:0];
      if (wrAck && isReg(address, `TM_COND_IDX_OFS))
        condIdx_q <= writedata[IDX_W-1:0];
      // A new event in the clearing cycle wins over the write of one.
      if (wrAck && isReg(address, `TM_IRQ_STAT_OFS))
        irqStat_q <= (irqStat_q & ~writedata[2:0]) | irqEvt;
      else
        irqStat_q <= irqStat_q | irqEvt;
      irq <= |(irqStat_q & irqMask_q);
      if (read && waitrequest)
      begin
        if (isReg(address, `TM_CTRL_OFS))
          readdata <= {27'h0, swErr_q, pause_q, 3'h0};
        else if (isReg(address, `TM_STATE_OFS))
          readdata <= {16'h0, faultFree, resultValid, state_q,
            selLatched_q, resultOut, selSync2_q};
        else if (isReg(address, `TM_IRQ_STAT_OFS))
          readdata <= {29'h0, irqStat_q};
        else if (isReg(address, `TM_IRQ_MASK_OFS))
          readdata <= {29'h0, irqMask_q};
        else if (isReg(address, `TM_COND_IDX_OFS))
          readdata <= {{(32-IDX_W){1'b0}}, condIdx_q};
        else if (isReg(address, `TM_COND_DATA_OFS))
          readdata <= {23'h0, workStore_q[condIdx_q]};
        else if (isReg(address, `TM_ZERO_CNT_OFS))
          readdata <= {16'h0, zeroCnt_q};
        else
          readdata <= 32'h00000000;
      end
    end
  end

endmodule // thresh_mon_port

// file: verification/thresh_mon_props.sv
// Checker for the discrete handshake port; it watches top-level ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module thresh_mon_props #(
  parameter NUM_COND = 16
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // Bus handshake.
  input wire read,
  input wire write,
  input wire waitrequest,
  // Discrete lines.
  input wire scanReq,
  input wire zeroStrobe,
  input wire [3:0] resultOut,
  input wire resultValid,
  input wire faultFree,
  // Engine side.
  input wire errorLed,
  input wire sensorSaturated,
  input wire zeroOffsetCmd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Steps of one bus access: request seen idle, one answer cycle, idle again.
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest ##1 waitrequest; endsequence
  AST_BUS_ONE_CYCLE: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  AST_CODE_BEFORE_VALID: assert property ($rose(resultValid) |-> $stable(resultOut))
    else $error("valid rose with code changing");
  AST_FROZEN_RESULT: assert property (resultValid |=> !resultValid || $stable(resultOut))
    else $error("result changed while valid");
  AST_LOW_REQ_CLEARS: assert property (!scanReq [*6] |-> !resultValid && resultOut == 4'h0)
    else $error("result not cleared after request low");
  AST_CLEAR_TOGETHER: assert property ($fell(resultValid) |-> resultOut == 4'h0)
    else $error("code left after valid fell");
  AST_ZERO_ON_RISE: assert property ($rose(zeroStrobe) |-> ##[3:4] zeroOffsetCmd)
    else $error("no zeroing after strobe rise");
  AST_ZERO_ONE_PULSE: assert property (zeroOffsetCmd |=> !zeroOffsetCmd)
    else $error("zeroing pulse too long");
  AST_FAULT_DROPS: assert property (sensorSaturated |=> !faultFree)
    else $error("fault line high during error");
  AST_LED_TRACKS: assert property (errorLed == !faultFree)
    else $error("indicator and fault line disagree");
endmodule // thresh_mon_props

bind thresh_mon_port thresh_mon_props #(.NUM_COND(NUM_COND)) u_props (.core_clk(core_clk),
  .rst(rst), .read(read), .write(write), .waitrequest(waitrequest), .scanReq(scanReq),
  .zeroStrobe(zeroStrobe), .resultOut(resultOut), .resultValid(resultValid),
  .faultFree(faultFree), .errorLed(errorLed), .sensorSaturated(sensorSaturated),
  .zeroOffsetCmd(zeroOffsetCmd));

// file: verification/ext_ctrl_model.sv
// Model of the external controller that drives the discrete lines.
// Assumes the bench calls its tasks; lines change just after core_clk rises.
`timescale 1ns/1ps
module ext_ctrl_model (
  // Clock.
  input wire core_clk,
  // Lines from the device.
  input wire [3:0] resultOut,
  input wire resultValid,
  // Lines to the device.
  output logic [3:0] selectIn,
  output logic scanReq,
  output logic zeroStrobe
);
  initial
  begin
    selectIn = 4'h0;
    scanReq = 1'b0;
    zeroStrobe = 1'b0;
  end
  // One handshake; hold sets how slowly the result is acknowledged.
  task automatic scan(input logic [3:0] code, input int hold, output logic [3:0] res);
    int n;
    begin
      n = 0;
      @(posedge core_clk);
      selectIn <= code;
      scanReq <= 1'b0;
      repeat (3) @(posedge core_clk);
      while (resultValid !== 1'b0 && n < 200)
      begin
        n++;
        @(posedge core_clk);
      end
      scanReq <= 1'b1;
      @(posedge core_clk);
      while (resultValid !== 1'b1 && n < 200)
      begin
        n++;
        @(posedge core_clk);
      end
      res = (resultValid === 1'b1) ? resultOut : 4'hX;
      repeat (hold) @(posedge core_clk);
      scanReq <= 1'b0;
    end
  endtask
  // Zeroing strobe held high for a number of cycles.
  task automatic strobe(input int high);
    zeroStrobe <= 1'b1;
    repeat (high) @(posedge core_clk);
    zeroStrobe <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
endmodule // ext_ctrl_model

// file: verification/tb.sv
// Self-checking bench for the discrete handshake port.
// Assumes the register header and the controller model are compiled first.
`timescale 1ns/1ps
`include "thresh_mon_regs.vh"
module tb;
  logic core_clk, rst, read, write, waitrequest, resultValid, faultFree, sensorSaturated;
  logic zeroStrobe, scanReq, errorLed, irq, zeroOffsetCmd, saveWorkingStoreCmd;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] selectIn, resultOut, r;
  logic [15:0] condTrue;
  int failures = 0;
  int n_checks = 0;
  int zeroPulses = 0;
  int savePulses = 0;
  thresh_mon_port DUT (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .selectIn(selectIn), .scanReq(scanReq), .zeroStrobe(zeroStrobe), .resultOut(resultOut),
    .resultValid(resultValid), .faultFree(faultFree), .condTrue(condTrue),
    .sensorSaturated(sensorSaturated), .zeroOffsetCmd(zeroOffsetCmd),
    .saveWorkingStoreCmd(saveWorkingStoreCmd),
    .errorLed(errorLed), .irq(irq));
  ext_ctrl_model ctrl (.core_clk(core_clk), .resultOut(resultOut), .resultValid(resultValid),
    .selectIn(selectIn), .scanReq(scanReq), .zeroStrobe(zeroStrobe));
  // Command pulses are counted here and compared at the end of t_zero and t_reload.
  always @(posedge core_clk)
  begin
    if (zeroOffsetCmd === 1'b1)
      zeroPulses <= zeroPulses + 1;
    if (saveWorkingStoreCmd === 1'b1)
      savePulses <= savePulses + 1;
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0)
      @(posedge core_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic put(input logic [3:0] i, input logic [8:0] v);
    bus(1'b1, `TM_COND_IDX_OFS, {28'h0, i});
    bus(1'b1, `TM_COND_DATA_OFS, {23'h0, v});
  endtask
  task automatic sc(input logic [3:0] code, input logic [3:0] exp, input int hold);
    ctrl.scan(code, hold, r);
    chk(32'(r), 32'(exp));
    repeat (8) @(posedge core_clk);
    chk({27'h0, resultValid, resultOut}, 32'h0);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Three enabled entries share a code, one is disabled, one has another code.
  task automatic t_scan;
    put(4'h0, 9'h125);
    put(4'h1, 9'h185);
    put(4'h2, 9'h1C5);
    put(4'h3, 9'h113);
    put(4'h4, 9'h0F5);
    bus(1'b1, `TM_CTRL_OFS, 32'h1);
    condTrue <= 16'h001F;
    sc(4'h5, 4'hE, 0);
    sc(4'h3, 4'h1, 20);
    condTrue <= 16'h0000;
    fork
      sc(4'h3, 4'h1, 2);
      begin
        repeat (40) @(posedge core_clk);
        chk({27'h0, resultValid, resultOut}, 32'h0);
        condTrue <= 16'h0008;
      end
    join
  endtask
  // Unmasked hit raises the line, write-one clears it, unmapped reads zero.
  task automatic t_irq;
    bus(1'b1, `TM_IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, `TM_IRQ_STAT_OFS, 32'h7);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
  endtask
  // Long and short strobes each zero once; a held level adds nothing.
  task automatic t_zero;
    ctrl.strobe(20);
    ctrl.strobe(2);
    bus(1'b0, `TM_ZERO_CNT_OFS, 32'h0);
    chk(q & 32'hFFFF, 32'h2);
    bus(1'b1, `TM_CTRL_OFS, 32'h4);
    bus(1'b0, `TM_ZERO_CNT_OFS, 32'h0);
    chk(q & 32'hFFFF, 32'h3);
    chk(zeroPulses, 3);
  endtask
  task automatic t_fault;
    sensorSaturated <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({30'h0, faultFree, errorLed}, 32'h1);
    sensorSaturated <= 1'b0;
    bus(1'b1, `TM_CTRL_OFS, 32'h10);
    repeat (2) @(posedge core_clk);
    chk(32'(faultFree), 32'h0);
    bus(1'b1, `TM_CTRL_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(faultFree), 32'h1);
  endtask
  // A request raised during a pause is served once the pause ends.
  task automatic t_pause;
    bus(1'b1, `TM_CTRL_OFS, 32'h8);
    condTrue <= 16'h0008;
    fork
      sc(4'h3, 4'h1, 0);
      begin
        repeat (30) @(posedge core_clk);
        chk({27'h0, resultValid, resultOut}, 32'h0);
        bus(1'b1, `TM_CTRL_OFS, 32'h0);
      end
    join
  endtask
  // An unsaved edit is undone by the reload command and lost across reset.
  task automatic t_reload;
    put(4'h0, 9'h000);
    bus(1'b0, `TM_COND_DATA_OFS, 32'h0);
    chk(q & 32'h1FF, 32'h0);
    bus(1'b1, `TM_CTRL_OFS, 32'h2);
    bus(1'b0, `TM_COND_DATA_OFS, 32'h0);
    chk(q & 32'h1FF, 32'h125);
    put(4'h0, 9'h000);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b1, `TM_COND_IDX_OFS, 32'h0);
    bus(1'b0, `TM_COND_DATA_OFS, 32'h0);
    chk(q & 32'h1FF, 32'h125);
    bus(1'b0, `TM_STATE_OFS, 32'h0);
    chk(q & 32'hC000, 32'h8000);
    chk(savePulses, 1);
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // The tests need well under 3000 cycles.
  initial
  begin
    #200000;
    failures++;
    print_verdict;
  end
  initial
  begin
    rst = 1'b1;
    {read, write, sensorSaturated} = 3'h0;
    address = 8'h00;
    writedata = 32'h0;
    condTrue = 16'h0000;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_scan;
    t_irq;
    t_zero;
    t_fault;
    t_pause;
    t_reload;
    print_verdict;
  end
endmodule // tb
